//--- rtl/eespt_host.sv
// Purpose: host controller driving a byte-wide parallel eeprom
// Assumes: data_lines input synchronous to clk; device access <= 120 ns
// Notes:   one request per byte; page writes held open via last flag
`timescale 1ns/1ps
module eespt_host (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic                 req_valid,
   output logic                      req_ready,
   input  wire eespt_pkg::eespt_req_t req,
   output logic                      rsp_valid,
   output logic [7:0]                rsp_data,
   output logic                      page_error,
   output eespt_pkg::eespt_pins_t    pins,
   output logic [7:0]                data_lines_o,
   output logic                      data_lines_oe,
   input  wire logic [7:0]           data_lines_i
);
   typedef enum logic [2:0] {
      S_IDLE, S_WLOW, S_WHIGH, S_RLOW, S_RHIGH
   } eespt_state_t;

   eespt_state_t state_reg;
   logic [12:0]  cnt_reg;
   logic         in_page_reg;
   logic [6:0]   page_reg;
   logic [6:0]   nbytes_reg;
   logic         polling_reg;
   logic         have_prev_reg;
   logic         prev_bit_reg;
   logic [12:0]  poll_addr_reg;
   logic         accept;
   logic         same_page;
   logic [12:0]  gap_reg;
   logic         page_open;

   assign req_ready = (state_reg == S_IDLE);
   assign accept    = req_valid && req_ready;
   assign same_page = req.addr[12:eespt_pkg::PAGE_LSB] == page_reg;
   // a page left idle past the byte load interval is already being written
   assign page_open = in_page_reg &&
                      gap_reg != 13'(eespt_pkg::BLC_CYC);

   // main sequencer; oe_n stays high through all write strobes
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg         <= S_IDLE;
         cnt_reg           <= '0;
         pins.ce_n         <= 1'b1;
         pins.we_n         <= 1'b1;
         pins.oe_n         <= 1'b1;
         pins.address_lines <= '0;
         data_lines_o      <= 8'h00;
         data_lines_oe     <= 1'b0;
      end else begin
         unique case (state_reg)
            S_IDLE: begin
               cnt_reg <= '0;
               if (accept && req.op == eespt_pkg::EESPT_OP_WRITE) begin
                  state_reg          <= S_WLOW;
                  pins.address_lines <= req.addr;
                  data_lines_o       <= req.data;
                  data_lines_oe      <= 1'b1;
                  pins.ce_n          <= 1'b0;
                  pins.we_n          <= 1'b0;
                  pins.oe_n          <= 1'b1;
               end else if (accept) begin
                  state_reg          <= S_RLOW;
                  pins.address_lines <= (req.op == eespt_pkg::EESPT_OP_POLL
                                         && polling_reg) ? poll_addr_reg
                                                         : req.addr;
                  pins.ce_n          <= 1'b0;
                  pins.oe_n          <= 1'b0;
                  data_lines_oe      <= 1'b0;
               end
            end
            S_WLOW: begin
               cnt_reg <= cnt_reg + 13'h0001;
               if (cnt_reg == 13'(eespt_pkg::WP_CYC - 1)) begin
                  pins.we_n <= 1'b1;
                  pins.ce_n <= 1'b1;
                  cnt_reg   <= '0;
                  state_reg <= S_WHIGH;
               end
            end
            S_WHIGH: begin
               cnt_reg <= cnt_reg + 13'h0001;
               if (cnt_reg == 13'(eespt_pkg::WPH_CYC - 1)) begin
                  data_lines_oe <= 1'b0;
                  state_reg     <= S_IDLE;
               end
            end
            S_RLOW: begin
               cnt_reg <= cnt_reg + 13'h0001;
               if (cnt_reg == 13'(eespt_pkg::ACC_CYC)) begin
                  pins.oe_n <= 1'b1;
                  pins.ce_n <= 1'b1;
                  cnt_reg   <= '0;
                  state_reg <= S_RHIGH;
               end
            end
            S_RHIGH: begin
               cnt_reg <= cnt_reg + 13'h0001;
               if (cnt_reg == 13'(eespt_pkg::OEHP_CYC - 1))
                  state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // read data captured at end of access
   always_ff @(posedge clk) begin
      if (reset) begin
         rsp_valid <= 1'b0;
         rsp_data  <= 8'h00;
      end else begin
         rsp_valid <= 1'b0;
         if (state_reg == S_RLOW && cnt_reg == 13'(eespt_pkg::ACC_CYC)) begin
            rsp_valid <= 1'b1;
            rsp_data  <= data_lines_i;
         end
      end
   end

   // page tracking: flag off-page bytes and over-long pages
   always_ff @(posedge clk) begin
      if (reset) begin
         in_page_reg <= 1'b0;
         page_reg    <= '0;
         nbytes_reg  <= '0;
         page_error  <= 1'b0;
      end else begin
         if (accept && req.op == eespt_pkg::EESPT_OP_WRITE) begin
            page_error <= page_open && (!same_page ||
                          nbytes_reg == 7'(eespt_pkg::PAGE_BYTES));
            page_reg   <= req.addr[12:eespt_pkg::PAGE_LSB];
            nbytes_reg <= (page_open ? nbytes_reg : 7'h00) + 7'h01;
            in_page_reg <= !req.last;
         end else if (accept) begin
            in_page_reg <= 1'b0;
         end else if (!page_open) begin
            in_page_reg <= 1'b0;
         end
      end
   end

   // cycles since the last byte was taken into the open page
   always_ff @(posedge clk) begin
      if (reset) begin
         gap_reg <= '0;
      end else if (accept && req.op == eespt_pkg::EESPT_OP_WRITE) begin
         gap_reg <= '0;
      end else if (page_open) begin
         gap_reg <= gap_reg + 13'h0001;
      end
   end

   // poll state: done when two successive reads agree
   always_ff @(posedge clk) begin
      if (reset) begin
         polling_reg   <= 1'b0;
         have_prev_reg <= 1'b0;
         prev_bit_reg  <= 1'b0;
         poll_addr_reg <= '0;
      end else begin
         if (accept && req.op == eespt_pkg::EESPT_OP_POLL && !polling_reg) begin
            polling_reg   <= 1'b1;
            poll_addr_reg <= req.addr;
         end else if (accept && req.op != eespt_pkg::EESPT_OP_POLL) begin
            polling_reg   <= 1'b0;
            have_prev_reg <= 1'b0;
         end
         if (rsp_valid && polling_reg) begin
            prev_bit_reg  <= rsp_data[eespt_pkg::TOGGLE_BIT];
            have_prev_reg <= 1'b1;
            if (have_prev_reg &&
                rsp_data[eespt_pkg::TOGGLE_BIT] == prev_bit_reg) begin
               polling_reg   <= 1'b0;
               have_prev_reg <= 1'b0;
            end
         end
      end
   end

   property p_oe_high_on_write;
      @(posedge clk) disable iff (reset)
         !pins.we_n |-> (pins.oe_n && !pins.ce_n);
   endproperty
   a_oe_high_on_write: assert property (p_oe_high_on_write)
      else $error("oe low during write strobe");

   property p_wp_width;
      @(posedge clk) disable iff (reset)
         $fell(pins.we_n) |-> !pins.we_n [*3];
   endproperty
   a_wp_width: assert property (p_wp_width)
      else $error("write pulse too short");

   sequence s_page_write;
      accept && req.op == eespt_pkg::EESPT_OP_WRITE && page_open;
   endsequence
   property p_off_page_flag;
      @(posedge clk) disable iff (reset)
         s_page_write ##0 !same_page |=> page_error;
   endproperty
   a_off_page_flag: assert property (p_off_page_flag)
      else $error("off-page byte not flagged");

   property p_page_full_flag;
      @(posedge clk) disable iff (reset)
         s_page_write ##0 nbytes_reg == 7'(eespt_pkg::PAGE_BYTES)
            |=> page_error;
   endproperty
   a_page_full_flag: assert property (p_page_full_flag)
      else $error("byte past a full page not flagged");

   property p_gap_close;
      @(posedge clk) disable iff (reset)
         in_page_reg && !page_open && !accept |=> !in_page_reg;
   endproperty
   a_gap_close: assert property (p_gap_close)
      else $error("page kept open past byte load interval");

   sequence s_read_start;
      $fell(pins.oe_n);
   endsequence
   property p_read_cycle;
      @(posedge clk) disable iff (reset)
         s_read_start |-> ##4 rsp_valid ##1 pins.oe_n [*3];
   endproperty
   a_read_cycle: assert property (p_read_cycle)
      else $error("read cycle timing wrong");

   property p_poll_addr;
      @(posedge clk) disable iff (reset)
         (polling_reg && !pins.oe_n && $past(polling_reg))
            |-> pins.address_lines == poll_addr_reg;
   endproperty
   a_poll_addr: assert property (p_poll_addr)
      else $error("poll address changed");
endmodule

//--- rtl/eespt_pkg.sv
// Purpose: constants and types for the parallel eeprom host controller
// Assumes: 25 MHz clk, synchronous active-high reset
// Notes:   pin timing counts are nanosecond minimums rounded up to clocks
//
// Summary of operation
// - one to sixty-four bytes follow a sequence; host still writes a 65th byte, raising page_error
// - page address bits fixed across page loads; host still writes an off-page byte, raising page_error
// - output enable high during all write strobes
// - each polling read toggles output enable
// - done when two reads match, no assumption
// - polling address held constant per sequence
// - next byte load within byte load interval
package eespt_pkg;
   localparam int CLK_NS         = 40;
   localparam int T_WP_NS        = 100;
   localparam int T_WPH_NS       = 50;
   localparam int T_ACC_NS       = 120;
   localparam int T_OEHP_NS      = 150;
   localparam int T_BLC_US       = 150;
   localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC  = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int OEHP_CYC = (T_OEHP_NS + CLK_NS - 1) / CLK_NS;
   localparam int BLC_CYC  = (T_BLC_US * 1000) / CLK_NS;
   localparam int PAGE_BYTES     = 64;
   localparam int ADDR_W         = 13;
   localparam int PAGE_LSB       = 6;
   localparam int TOGGLE_BIT     = 6;

   typedef enum logic [1:0] {
      EESPT_OP_READ,
      EESPT_OP_WRITE,
      EESPT_OP_POLL
   } eespt_op_t;

   typedef struct packed {
      eespt_op_t         op;
      logic [12:0]       addr;
      logic [7:0]        data;
      logic              last;
   } eespt_req_t;

   typedef struct packed {
      logic              ce_n;
      logic              we_n;
      logic              oe_n;
      logic [12:0]       address_lines;
   } eespt_pins_t;
endpackage

//--- tb/eespt_dev_model.sv
// Purpose: behavioural parallel eeprom seen by the host controller
// Assumes: pins come registered from the host on clk
// Notes:   internal write time shortened to BUSY_CYC clocks
`timescale 1ns/1ps
module eespt_dev_model #(
   parameter int          BUSY_CYC = 40,
   parameter logic [12:0] CMD_ADDR = 13'h1F00, // arbitrary command address
   parameter logic [7:0]  CMD_ON   = 8'hE1,    // arbitrary enable code
   parameter logic [7:0]  CMD_OFF  = 8'hE2     // arbitrary disable code
) (
   input  wire logic                   clk,
   input  wire eespt_pkg::eespt_pins_t pins,
   input  wire logic [7:0]             wdata,
   input  wire logic                   wdata_oe,
   output logic [7:0]                  rdata
);
   logic [7:0] mem [0:8191];
   logic       wr_act;
   logic       rd_act;
   logic       tog_reg = 1'b0;
   logic [7:0] last_reg = 8'h00;
   int         busy_cnt = 0;
   logic       wr_prev = 1'b0;
   logic       prot_reg = 1'b0;
   logic       arm_on = 1'b0;
   logic       arm_off = 1'b0;
   assign wr_act = !pins.ce_n && !pins.we_n;
   assign rd_act = !pins.ce_n && !pins.oe_n && pins.we_n;
   always @(posedge clk) begin
      wr_prev <= wr_act;
      if (wr_act) busy_cnt <= BUSY_CYC;
      else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
      // protection changes only as the write period ends
      if (!wr_act && busy_cnt == 1) begin
         if (arm_on) prot_reg <= 1'b1;
         if (arm_off) prot_reg <= 1'b0;
         arm_on  <= 1'b0;
         arm_off <= 1'b0;
      end
      // byte taken as its strobe closes; any count, no page limit
      if (wr_prev && !wr_act && wdata_oe) begin
         if (pins.address_lines == CMD_ADDR && wdata == CMD_ON)
            arm_on <= 1'b1;
         else if (pins.address_lines == CMD_ADDR && wdata == CMD_OFF)
            arm_off <= 1'b1;
         else if (!prot_reg || arm_on || arm_off)
            mem[pins.address_lines] <= wdata;
      end
      if (rd_act) last_reg <= rdata;
   end
   // either strobe opening a read flips the bit while busy
   always @(posedge rd_act) begin
      if (busy_cnt > 0) tog_reg = ~tog_reg;
   end
   // released bus shows the inverse of the last value
   always_comb begin
      rdata = ~last_reg;
      if (rd_act) rdata = mem[pins.address_lines];
      if (rd_act && busy_cnt > 0) rdata[6] = tog_reg;
   end
endmodule

//--- tb/eespt_host_test.sv
// Purpose: self-checking bench for the eeprom host controller
// Assumes: device model on the pins, 25 MHz clk
// Notes:   only mismatches and the verdict are printed
`timescale 1ns/1ps
module eespt_host_test;
   logic                   clk = 1'b0;
   logic                   reset = 1'b1;
   logic                   req_valid = 1'b0;
   eespt_pkg::eespt_req_t  req = '0;
   logic                   req_ready, rsp_valid, page_error, data_lines_oe;
   logic [7:0]             rsp_data, data_lines_o, data_lines_i, r1, r2;
   eespt_pkg::eespt_pins_t pins;
   int                     error_cnt = 0;
   int                     checked = 0;
   int                     cyc = 0;
   localparam logic [12:0] CMD_ADDR = 13'h1F00; // arbitrary
   localparam logic [7:0]  CMD_ON   = 8'hE1;    // arbitrary
   localparam logic [7:0]  CMD_OFF  = 8'hE2;    // arbitrary
   initial forever #20 clk = ~clk;
   eespt_host eespt_host_inst (.clk(clk), .reset(reset),
      .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .page_error(page_error), .pins(pins), .data_lines_o(data_lines_o),
      .data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i));
   eespt_dev_model #(.CMD_ADDR(CMD_ADDR), .CMD_ON(CMD_ON),
      .CMD_OFF(CMD_OFF)) eespt_dev_model_inst (.clk(clk), .pins(pins),
      .wdata(data_lines_o), .wdata_oe(data_lines_oe),
      .rdata(data_lines_i));
   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (error_cnt == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic issue(eespt_pkg::eespt_op_t op, logic [12:0] a,
                        logic [7:0] d, logic l);
      @(posedge clk);
      #1 req_valid = 1'b1;
      req = '{op, a, d, l};
      do @(negedge clk); while (req_ready !== 1'b1);
      @(posedge clk);
      #1 req_valid = 1'b0;
   endtask
   task automatic get(output logic [7:0] d);
      int n;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n == 2000) begin
         error_cnt++;
         close_out();
      end else begin
         d = rsp_data;
      end
   endtask
   task automatic rd(logic [12:0] a, output logic [7:0] d);
      issue(eespt_pkg::EESPT_OP_READ, a, 8'h00, 1'b0);
      get(d);
   endtask
   task automatic poll(logic [12:0] a);
      logic [7:0] prev;
      int         n;
      n = 0;
      issue(eespt_pkg::EESPT_OP_POLL, a, 8'h00, 1'b0);
      get(r1);
      do begin
         prev = r1;
         issue(eespt_pkg::EESPT_OP_POLL, a ^ 13'h0001, 8'h00, 1'b0);
         get(r1);
         chk(pins.address_lines, a);
         n++;
      end while (r1[6] != prev[6] && n < 100);
      chk(r1[6] ^ prev[6], 16'h0000);
   endtask
   task automatic t_toggle();
      issue(eespt_pkg::EESPT_OP_WRITE, 13'h0040, 8'hA5, 1'b1);
      @(negedge clk);
      chk(page_error, 16'h0000);
      rd(13'h0040, r1);
      rd(13'h0040, r2);
      chk(r1[6] ^ r2[6], 16'h0001);
      chk({r1[7], r1[5:0]}, 16'h0065);
      poll(13'h0040);
      rd(13'h0040, r1);
      chk(r1, 16'h00A5);
   endtask
   task automatic t_page();
      for (int i = 0; i < 65; i++) begin
         issue(eespt_pkg::EESPT_OP_WRITE, 13'h0080 + 13'(i & 63),
               i[7:0] ^ 8'h3C, i == 64);
         if (i == 63) chk(page_error, 16'h0000);
      end
      @(negedge clk);
      chk(page_error, 16'h0001);
      poll(13'h0090);
      rd(13'h0080, r1);
      chk(r1, 16'h007C);
      rd(13'h00BF, r1);
      chk(r1, 16'h0003);
      issue(eespt_pkg::EESPT_OP_WRITE, 13'h00FF, 8'h11, 1'b0);
      issue(eespt_pkg::EESPT_OP_WRITE, 13'h0100, 8'h22, 1'b1);
      @(negedge clk);
      chk(page_error, 16'h0001);
      poll(13'h0100);
   endtask
   task automatic t_gap();
      issue(eespt_pkg::EESPT_OP_WRITE, 13'h0200, 8'h44, 1'b0);
      repeat (eespt_pkg::BLC_CYC + 8) @(posedge clk);
      issue(eespt_pkg::EESPT_OP_WRITE, 13'h0240, 8'h55, 1'b1);
      @(negedge clk);
      chk(page_error, 16'h0000);
      poll(13'h0240);
      rd(13'h0200, r1);
      chk(r1, 16'h0044);
   endtask
   task automatic t_protect();
      issue(eespt_pkg::EESPT_OP_WRITE, 13'h0300, 8'h5A, 1'b1);
      poll(13'h0300);
      issue(eespt_pkg::EESPT_OP_WRITE, CMD_ADDR, CMD_ON, 1'b1);
      poll(13'h0300);
      issue(eespt_pkg::EESPT_OP_WRITE, 13'h0300, 8'hC3, 1'b1);
      poll(13'h0300);
      rd(13'h0300, r1);
      chk(r1, 16'h005A);
      issue(eespt_pkg::EESPT_OP_WRITE, CMD_ADDR, CMD_OFF, 1'b1);
      poll(13'h0300);
      issue(eespt_pkg::EESPT_OP_WRITE, 13'h0300, 8'hC3, 1'b1);
      poll(13'h0300);
      rd(13'h0300, r1);
      chk(r1, 16'h00C3);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      t_toggle();
      t_page();
      t_gap();
      t_protect();
      close_out();
   end
endmodule
